// file: timer8_pkg.sv
// Constants, field positions and types of the 8-bit waveform timer.
// Assumes a single 100 MHz clock and an Avalon-MM register slave.
// How it works
// - Mode 0 counts up, wraps 0xFF to 0x00.
// - Normal mode: overflow set when count becomes zero.
// - Mode 2 clears counter on compare_a match.
// - Clear-on-compare sets match_flag_a at top.
// - Clear-on-compare compare_a unbuffered; missed match wraps.
// - Clear-on-compare output mode 1 toggles wave_out_a.
// - Clear-on-compare overflow set on wrap to zero.
// - Modes 3/7 single slope, top 0xFF or compare_a.
// - Fast PWM clears counter the tick after top.
// - Fast PWM sets overflow at top.
// - Fast PWM mode 2 clear-match/set-bottom; 3 inverse.
// - Fast PWM toggle only channel A with mode_bit2.
// - Fast PWM extremes: spike at bottom, constant at max.
// - Fast PWM compare values are double buffered.
// - Modes 1/5 dual slope, top 0xFF or compare_a.
// - Phase-correct holds top for one tick.
// - Phase-correct mode 2 clear-up/set-down; 3 inverse.
// - Phase-correct sets overflow at bottom.
// - Phase-correct toggle only channel A with mode_bit2.
// - Phase-correct extremes give constant output levels.
// - Phase-correct output fixed at bottom for symmetry.
// - Tick is clock divided by 1/8/64/256/1024.
// - Match sets match flag; software writes one clears.
// - Count write blocks matches for next tick.
// - Force updates output in non-PWM, no flag/clear.
// - Output mode 0 no action; changes apply next match.
package timer8_pkg;

  localparam logic [4:0] addr_ctrl_a   = 5'h00;
  localparam logic [4:0] addr_ctrl_b   = 5'h04;
  localparam logic [4:0] addr_count    = 5'h08;
  localparam logic [4:0] addr_compare_a = 5'h0C;
  localparam logic [4:0] addr_compare_b = 5'h10;
  localparam logic [4:0] addr_flags    = 5'h14;

  localparam int com_a_pos    = 6;
  localparam int com_b_pos    = 4;
  localparam int force_a_pos  = 7;
  localparam int force_b_pos  = 6;
  localparam int mode_bit2_pos = 3;
  localparam int flag_ovf_pos = 0;
  localparam int flag_a_pos   = 1;
  localparam int flag_b_pos   = 2;

  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [7:0] count_max  = 8'hFF;
  localparam logic [7:0] count_bottom = 8'h00;

  localparam logic [2:0] mode_normal = 3'h0;
  localparam logic [2:0] mode_phase_ff = 3'h1;
  localparam logic [2:0] mode_clear  = 3'h2;
  localparam logic [2:0] mode_fast_ff = 3'h3;
  localparam logic [2:0] mode_phase_oa = 3'h5;
  localparam logic [2:0] mode_fast_oa = 3'h7;

  // Terminal counts of the prescaler for clock select codes 1 to 5.
  localparam logic [9:0] div_1_term    = 10'h000;
  localparam logic [9:0] div_8_term    = 10'h007;
  localparam logic [9:0] div_64_term   = 10'h03F;
  localparam logic [9:0] div_256_term  = 10'h0FF;
  localparam logic [9:0] div_1024_term = 10'h3FF;

  typedef enum logic [1:0] {kind_normal, kind_clear, kind_fast, kind_phase} kind_type;
  typedef enum logic {dir_up, dir_down} dir_type;

endpackage

// file: timer8.sv
// Counter, compare channels, waveform outputs and register slave.
// Assumes an Avalon-MM master holding requests until waitrequest is low.
`timescale 1ns/1ns
`default_nettype none
module timer8 (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             wave_out_a_o,
  output logic             wave_out_b_o
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic timer8_pkg::kind_type kind_of(input logic [2:0] m);
    unique case (m)
      timer8_pkg::mode_clear: kind_of = timer8_pkg::kind_clear;
      timer8_pkg::mode_fast_ff,
      timer8_pkg::mode_fast_oa: kind_of = timer8_pkg::kind_fast;
      timer8_pkg::mode_phase_ff,
      timer8_pkg::mode_phase_oa: kind_of = timer8_pkg::kind_phase;
      default: kind_of = timer8_pkg::kind_normal;
    endcase
  endfunction

  function automatic logic [9:0] term_of(input logic [2:0] cs);
    unique case (cs)
      3'h1: term_of = timer8_pkg::div_1_term;
      3'h2: term_of = timer8_pkg::div_8_term;
      3'h3: term_of = timer8_pkg::div_64_term;
      3'h4: term_of = timer8_pkg::div_256_term;
      default: term_of = timer8_pkg::div_1024_term;
    endcase
  endfunction

  // Next level of one compare output.
  function automatic logic wave_next(
    input logic                  cur,
    input logic [1:0]            com,
    input timer8_pkg::kind_type  k,
    input logic                  may_toggle,
    input logic                  hit,
    input logic                  force_now,
    input logic                  at_top,
    input logic                  at_bottom,
    input logic                  falling,
    input logic                  cmp_zero,
    input logic                  cmp_top
  );
    logic r;
    r = cur;
    unique case (k)
      timer8_pkg::kind_normal,
      timer8_pkg::kind_clear: begin
        if (hit || force_now) begin
          unique case (com)
            2'h1: r = ~cur;
            2'h2: r = 1'b0;
            2'h3: r = 1'b1;
            default: r = cur;
          endcase
        end
      end
      timer8_pkg::kind_fast: begin
        if (com == 2'h1) begin
          if (hit && may_toggle) begin
            r = ~cur;
          end
        end else if (com[1]) begin
          if (at_top) begin
            r = ~com[0];
          end else if (hit && !cmp_top) begin
            r = com[0];
          end
        end
      end
      default: begin
        if (com == 2'h1) begin
          if (hit && may_toggle) begin
            r = ~cur;
          end
        end else if (com[1]) begin
          if (at_bottom) begin
            r = cmp_zero ? com[0] : ~com[0];
          end else if (hit) begin
            r = falling ? ~com[0] : com[0];
          end
        end
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register slave: every access takes one wait cycle.

  logic       wait_r;
  logic [7:0] rdata_nxt;
  logic       wr_en;
  logic [1:0] com_a_r;
  logic [1:0] com_b_r;
  logic [2:0] mode_r;
  logic [2:0] cs_r;
  logic [7:0] cnt_r;
  logic [7:0] cmp_a_buf_r;
  logic [7:0] cmp_b_buf_r;
  logic [7:0] cmp_a_r;
  logic [7:0] cmp_b_r;
  logic       ovf_r;
  logic       flag_a_r;
  logic       flag_b_r;

  assign wr_en = avs_write_i && !wait_r && avs_byteenable_i[0];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((avs_read_i || avs_write_i) && wait_r);
    end
  end

  assign avs_waitrequest_o = wait_r;

  always_comb begin
    unique case (avs_address_i)
      timer8_pkg::addr_ctrl_a:
        rdata_nxt = {com_a_r, com_b_r, 2'h0, mode_r[1:0]};
      timer8_pkg::addr_ctrl_b:
        rdata_nxt = {4'h0, mode_r[2], cs_r};
      timer8_pkg::addr_count: rdata_nxt = cnt_r;
      timer8_pkg::addr_compare_a: rdata_nxt = cmp_a_buf_r;
      timer8_pkg::addr_compare_b: rdata_nxt = cmp_b_buf_r;
      timer8_pkg::addr_flags: rdata_nxt = {5'h00, flag_b_r, flag_a_r, ovf_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && wait_r) begin
      avs_readdata_o <= {24'h00_0000, rdata_nxt};
    end
  end

  logic wr_ctrl_b;
  logic wr_count;
  logic wr_flags;
  assign wr_ctrl_b = wr_en && avs_address_i == timer8_pkg::addr_ctrl_b;
  assign wr_count  = wr_en && avs_address_i == timer8_pkg::addr_count;
  assign wr_flags  = wr_en && avs_address_i == timer8_pkg::addr_flags;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      com_a_r <= 2'h0;
      com_b_r <= 2'h0;
      mode_r  <= timer8_pkg::mode_normal;
      cs_r    <= 3'h0;
    end else begin
      if (wr_en && avs_address_i == timer8_pkg::addr_ctrl_a) begin
        com_a_r    <= avs_writedata_i[timer8_pkg::com_a_pos +: 2];
        com_b_r    <= avs_writedata_i[timer8_pkg::com_b_pos +: 2];
        mode_r[1:0] <= avs_writedata_i[1:0];
      end
      if (wr_ctrl_b) begin
        mode_r[2] <= avs_writedata_i[timer8_pkg::mode_bit2_pos];
        cs_r      <= avs_writedata_i[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler.

  logic [9:0] pre_r;
  logic [2:0] cs_last_r;
  logic       tick;

  assign tick = cs_r >= 3'h1 && cs_r <= 3'h5 && pre_r == term_of(cs_r);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_r     <= 10'h000;
      cs_last_r <= 3'h0;
    end else begin
      cs_last_r <= cs_r;
      if (tick || cs_r != cs_last_r) begin
        pre_r <= 10'h000;
      end else begin
        pre_r <= pre_r + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter and compare.

  timer8_pkg::kind_type kind;
  timer8_pkg::dir_type  dir_r;
  logic [7:0] top;
  logic       block_r;
  logic       hit_a;
  logic       hit_b;
  logic       at_top;
  logic       at_bottom;
  logic       pwm;

  assign kind = kind_of(mode_r);
  assign pwm  = kind == timer8_pkg::kind_fast || kind == timer8_pkg::kind_phase;
  assign top  = mode_r[2] ? cmp_a_r : timer8_pkg::count_max;
  assign hit_a = tick && !block_r && cnt_r == cmp_a_r;
  assign hit_b = tick && !block_r && cnt_r == cmp_b_r;
  assign at_top = tick && cnt_r == top;
  assign at_bottom = tick && dir_r == timer8_pkg::dir_down && cnt_r == timer8_pkg::count_bottom;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      block_r <= 1'b0;
    end else if (wr_count) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= timer8_pkg::reset_byte;
      dir_r <= timer8_pkg::dir_up;
    end else if (wr_count) begin
      cnt_r <= avs_writedata_i[7:0];
    end else if (tick) begin
      unique case (kind)
        timer8_pkg::kind_clear: begin
          cnt_r <= hit_a ? timer8_pkg::count_bottom : cnt_r + 8'h01;
        end
        timer8_pkg::kind_fast: begin
          cnt_r <= at_top ? timer8_pkg::count_bottom : cnt_r + 8'h01;
        end
        timer8_pkg::kind_phase: begin
          if (dir_r == timer8_pkg::dir_up) begin
            if (cnt_r >= top) begin
              dir_r <= timer8_pkg::dir_down;
              cnt_r <= cnt_r == timer8_pkg::count_bottom ? cnt_r : cnt_r - 8'h01;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end else if (cnt_r == timer8_pkg::count_bottom) begin
            dir_r <= timer8_pkg::dir_up;
            cnt_r <= cnt_r + 8'h01;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          cnt_r <= cnt_r + 8'h01;
        end
      endcase
    end
  end

  // Software sees the buffers; PWM loads them at top only.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_a_buf_r <= timer8_pkg::reset_byte;
      cmp_b_buf_r <= timer8_pkg::reset_byte;
      cmp_a_r     <= timer8_pkg::reset_byte;
      cmp_b_r     <= timer8_pkg::reset_byte;
    end else begin
      if (wr_en && avs_address_i == timer8_pkg::addr_compare_a) begin
        cmp_a_buf_r <= avs_writedata_i[7:0];
      end
      if (wr_en && avs_address_i == timer8_pkg::addr_compare_b) begin
        cmp_b_buf_r <= avs_writedata_i[7:0];
      end
      if (!pwm || at_top) begin
        cmp_a_r <= cmp_a_buf_r;
        cmp_b_r <= cmp_b_buf_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags; a set in the clearing cycle wins.

  logic ovf_set;
  always_comb begin
    unique case (kind)
      timer8_pkg::kind_fast: ovf_set = at_top;
      timer8_pkg::kind_phase: ovf_set = at_bottom;
      default: ovf_set = tick && cnt_r == timer8_pkg::count_max;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_r    <= 1'b0;
      flag_a_r <= 1'b0;
      flag_b_r <= 1'b0;
    end else begin
      ovf_r    <= (ovf_r && !(wr_flags && avs_writedata_i[timer8_pkg::flag_ovf_pos])) || ovf_set;
      flag_a_r <= (flag_a_r && !(wr_flags && avs_writedata_i[timer8_pkg::flag_a_pos])) || hit_a;
      flag_b_r <= (flag_b_r && !(wr_flags && avs_writedata_i[timer8_pkg::flag_b_pos])) || hit_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waveform outputs.

  logic force_a;
  logic force_b;
  logic falling;
  assign force_a = wr_ctrl_b && !pwm && avs_writedata_i[timer8_pkg::force_a_pos];
  assign force_b = wr_ctrl_b && !pwm && avs_writedata_i[timer8_pkg::force_b_pos];
  assign falling = dir_r == timer8_pkg::dir_down || cnt_r == top;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wave_out_a_o <= 1'b0;
      wave_out_b_o <= 1'b0;
    end else begin
      wave_out_a_o <= wave_next(wave_out_a_o, com_a_r, kind, mode_r[2], hit_a, force_a,
                                at_top, at_bottom, falling, cmp_a_r == timer8_pkg::count_bottom,
                                cmp_a_r == top);
      wave_out_b_o <= wave_next(wave_out_b_o, com_b_r, kind, 1'b0, hit_b, force_b,
                                at_top, at_bottom, falling, cmp_b_r == timer8_pkg::count_bottom,
                                cmp_b_r == top);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_normal_wrap: assert property (
    kind == timer8_pkg::kind_normal && tick && !wr_count && cnt_r == 8'hFF
    |=> cnt_r == 8'h00 && ovf_r) else $error("normal mode did not wrap");

  a_compare_clear: assert property (
    kind == timer8_pkg::kind_clear && hit_a && !wr_count
    |=> cnt_r == 8'h00 && flag_a_r) else $error("clear on compare missed");

  a_fast_restart: assert property (
    kind == timer8_pkg::kind_fast && at_top && !wr_count
    |=> cnt_r == 8'h00 && ovf_r) else $error("fast mode did not restart");

  a_phase_turn: assert property (
    kind == timer8_pkg::kind_phase && tick && !wr_count && dir_r == timer8_pkg::dir_up
    && cnt_r == top && top != 8'h00
    |=> dir_r == timer8_pkg::dir_down && cnt_r == $past(cnt_r) - 8'h01)
    else $error("phase mode did not turn at top");

  a_block_match: assert property (
    tick && block_r && cnt_r == cmp_a_r && !flag_a_r && !wr_flags
    |=> !flag_a_r) else $error("match not blocked after count write");

  a_force_toggle: assert property (
    force_a && com_a_r == 2'h1 && !hit_a && !flag_a_r
    |=> wave_out_a_o != $past(wave_out_a_o) && !flag_a_r)
    else $error("force did not toggle output");

  a_buffer_hold: assert property (
    pwm && !at_top ##1 !at_top |-> $stable(cmp_a_r)) else $error("PWM compare changed mid cycle");

  a_flag_clear: assert property (
    wr_flags && avs_writedata_i[timer8_pkg::flag_a_pos] && !hit_a
    |=> !flag_a_r) else $error("match flag not cleared");

  a_div8_gap: assert property (
    tick && cs_r == 3'h2 && cs_last_r == 3'h2 |=> (!tick)[*7]) else $error("prescale by 8 too fast");

  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && wait_r |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");

  c_compare_match: cover property (kind == timer8_pkg::kind_clear && hit_a);
  c_fast_top: cover property (kind == timer8_pkg::kind_fast && at_top && com_a_r == 2'h2);
  c_phase_bottom: cover property (kind == timer8_pkg::kind_phase && at_bottom);
  c_forced: cover property (force_b);

endmodule
`default_nettype wire

// file: timer8_tb.sv
// Self-checking testbench for the 8-bit waveform timer.
// Assumes timer8 and timer8_pkg; the bench drives the Avalon-MM slave itself.
`timescale 1ns/1ns
`default_nettype none
module timer8_tb;
  typedef struct {bit en; logic [31:0] v;} note_type;
  logic        clk_i;
  logic        rst_n_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        wave_out_a_o;
  logic        wave_out_b_o;
  int          failures = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          lcyc;
  int          c0;
  int          d;
  int          dl;
  int          divs [6] = '{0, 1, 8, 64, 256, 1024};
  integer      seed = 32'hA046E1B8;
  note_type    notes [$];
  note_type    head;
  logic [4:0]  regs [8];
  logic [7:0]  rd, r0, cnt, top, cmpa, npa, cmp_b;
  logic        wa, wb, sa, sb, up, blk, hooked, atop;
  logic [1:0]  com_a, com_b;
  int          kind;

  timer8 timer8_inst (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .wave_out_a_o      (wave_out_a_o),
    .wave_out_b_o      (wave_out_b_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) cyc <= cyc + 1;

////////////////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: word %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_level(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: level %b expected %b", $time, got, exp);
    end
  endtask

  // The oldest note belongs to the read that completes at this edge.
  always @(posedge clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && notes.size() > 0) begin
      head = notes.pop_front();
      if (head.en) check_word(avs_readdata_o, head.v);
    end
  end

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    $display("CHECK FAILED at %0t: timeout", $time);
    summarize();
  end

////////////////////////////////////////////////////////////////////////////////
  task automatic bus_write(input logic [4:0] a, input logic [7:0] v, input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i    <= a;
    avs_writedata_i  <= {24'($random(seed)), v};
    avs_byteenable_i <= be;
    avs_write_i      <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask

  // Outputs are sampled at the edge that loads the read data, so they match it.
  task automatic bus_read(input logic [4:0] a, input bit en, input logic [7:0] exp);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    notes.push_back('{en, {24'h000000, exp}});
    @(posedge clk_i);
    sa   = wave_out_a_o;
    sb   = wave_out_b_o;
    lcyc = cyc;
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    rd = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] exp);
    bus_read(a, 1'b1, exp);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    {wa, wb, up, hooked} = 4'h2;
  endtask

////////////////////////////////////////////////////////////////////////////////
  function automatic logic wnext(logic w, logic [1:0] c, logic [7:0] o, logic u, logic [7:0] m);
    if (c == 2'h0) return w;
    if (kind == 1 && c[1] && o == top) return ~c[0];
    if (o != m || blk) return w;
    if (c == 2'h1) return ~w;
    return (kind == 2 && !u) ? ~c[0] : c[0];
  endfunction

  task automatic step();
    logic [7:0] o;
    o   = cnt;
    wa  = wnext(wa, com_a, o, up && o != top, cmpa);
    wb  = wnext(wb, com_b, o, up && o != top, cmp_b);
    if (kind == 2) begin
      if (up && o == top) {up, cnt} = {1'b0, o - 8'h01};
      else if (!up && o == 8'h00) {up, cnt} = {1'b1, 8'h01};
      else cnt = up ? o + 8'h01 : o - 8'h01;
    end else cnt = (o == top && !blk) ? 8'h00 : o + 8'h01;
    if (kind != 0 && o == top) begin
      cmpa = npa;
      if (atop) top = npa;
    end
    blk = 1'b0;
  endtask

  // Polls the count and checks every change against the model.
  task automatic walk(input int n, input logic [7:0] at, input logic [7:0] nv);
    int i;
    int t;
    i = 0;
    t = 0;
    while (i < n && t < 10 * n) begin
      bus_read(timer8_pkg::addr_count, 1'b0, 8'h00);
      t++;
      if (rd !== cnt) begin
        step();
        i++;
        check_word({24'h000000, rd}, {24'h000000, cnt});
        check_level(sa, wa);
        check_level(sb, wb);
        if (rd === at && !hooked) begin
          hooked = 1'b1;
          npa    = nv;
          bus_write(timer8_pkg::addr_compare_a, nv, 4'hF);
        end
      end
    end
    if (i < n) begin
      failures++;
      $display("CHECK FAILED at %0t: count stalled", $time);
    end
  endtask

  task automatic run(input logic [7:0] ca, cb, c, va, vb, input int n, input logic [7:0] at, nv, fx);
    do_reset();
    kind  = (ca[1:0] == 2'h3) ? 1 : (ca[1:0] == 2'h1) ? 2 : 0;
    atop  = (ca[1:0] == 2'h2) || (ca[0] && cb[3]);
    top   = atop ? va : timer8_pkg::count_max;
    {com_a, com_b, cmpa, npa, cmp_b, cnt, blk} = {ca[7:4], va, va, vb, c, 1'b1};
    bus_write(timer8_pkg::addr_compare_a, va, 4'hF);
    bus_write(timer8_pkg::addr_compare_b, vb, 4'hF);
    bus_write(timer8_pkg::addr_count, c, 4'hF);
    bus_write(timer8_pkg::addr_ctrl_a, ca, 4'hF);
    bus_write(timer8_pkg::addr_ctrl_b, cb, 4'hF);
    walk(n, at, nv);
    rc(timer8_pkg::addr_flags, fx);
    $display("test mode %0h com %0h done", ca[1:0] | {cb[3], 2'h0}, ca[7:4]);
  endtask

////////////////////////////////////////////////////////////////////////////////
  initial begin
    regs = '{timer8_pkg::addr_ctrl_a, timer8_pkg::addr_ctrl_b, timer8_pkg::addr_count,
             timer8_pkg::addr_compare_a, timer8_pkg::addr_compare_b, timer8_pkg::addr_flags, 5'h18, 5'h1C};
    {rst_n_i, avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, avs_byteenable_i} = '0;
    repeat (16) @(posedge clk_i);
    check_level(avs_waitrequest_o, 1'b1);
    check_level(wave_out_a_o, 1'b0);
    check_level(wave_out_b_o, 1'b0);
    rst_n_i <= 1'b1;
    foreach (regs[i]) rc(regs[i], 8'h00);
    bus_write(timer8_pkg::addr_compare_a, 8'h5A, 4'hE);
    rc(timer8_pkg::addr_compare_a, 8'h00);
    bus_write(5'h18, 8'($random(seed)), 4'hF);
    rc(5'h18, 8'h00);
    $display("test reset_and_access done");
    run(8'h00, 8'h02, 8'hFC, 8'h00, 8'hFE, 6, 8'h00, 8'h00, 8'h07);
    bus_write(timer8_pkg::addr_flags, 8'h03, 4'hF);
    rc(timer8_pkg::addr_flags, 8'h04);
    run(8'h42, 8'h02, 8'h00, 8'h03, 8'h00, 9, 8'hFF, 8'h03, 8'h06);
    run(8'h42, 8'h02, 8'h05, 8'h02, 8'h00, 255, 8'hFF, 8'h02, 8'h07);
    run(8'h42, 8'h02, 8'h03, 8'h03, 8'h00, 258, 8'hFF, 8'h03, 8'h07);
    for (int k = 2; k < 4; k++) begin
      run(8'h43 | 8'(k << 4), 8'h0A, 8'h00, 8'h04, 8'h02, 14, 8'h03, 8'h02, 8'h07);
      run(8'h01 | 8'(k << 4), 8'h0A, 8'h00, 8'h03, 8'h01, 14, 8'hFF, 8'h03, 8'h07);
    end
    do_reset();
    for (int k = 0; k < 4; k++) begin
      bus_write(timer8_pkg::addr_ctrl_a, 8'(k << 4), 4'hF);
      bus_write(timer8_pkg::addr_ctrl_b, 8'h40, 4'hF);
      wb = (k == 0) ? wb : (k == 1) ? ~wb : k[0];
      repeat (2) @(posedge clk_i);
      check_level(wave_out_b_o, wb);
    end
    bus_write(timer8_pkg::addr_ctrl_a, 8'h40, 4'hF);
    bus_write(timer8_pkg::addr_ctrl_b, 8'h80, 4'hF);
    repeat (2) @(posedge clk_i);
    check_level(wave_out_a_o, 1'b1);
    rc(timer8_pkg::addr_flags, 8'h00);
    rc(timer8_pkg::addr_count, 8'h00);
    $display("test force done");
    for (int k = 0; k < 6; k++) begin
      bus_write(timer8_pkg::addr_ctrl_b, 8'(k), 4'hF);
      bus_read(timer8_pkg::addr_count, 1'b0, 8'h00);
      {r0, c0} = {rd, lcyc};
      repeat (3 * divs[k] + 2) @(posedge clk_i);
      bus_read(timer8_pkg::addr_count, 1'b0, 8'h00);
      d  = lcyc - c0;
      dl = int'(8'(rd - r0));
      check_word(32'(k == 0 ? dl == 0 : (dl * divs[k] > d - divs[k] && dl * divs[k] < d + divs[k])), 32'h1);
    end
    $display("test prescaler done");
    summarize();
  end
endmodule
`default_nettype wire
